// ---- verilog/rftcs_pkg.sv ----
// Package of offsets, field positions and reset values for the transmitter control and status registers.
package rftcs_pkg;

  // ************************************************************
  // Bus shape
  // ************************************************************
  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;

  // ************************************************************
  // Register indices
  // ************************************************************
  localparam logic [ADDR_W-1:0] IDX_FRAME_TIMING = 2'h0;
  localparam logic [ADDR_W-1:0] IDX_STATUS_CTRL = 2'h1;
  localparam logic [ADDR_W-1:0] IDX_DIV_HIGH = 2'h2;
  localparam logic [ADDR_W-1:0] IDX_DIV_LOW_ENC = 2'h3;

  // ************************************************************
  // Frame slot timing fields
  // ************************************************************
  localparam int TIMER_LSB = 0;
  localparam int TIMER_MSB = 5;
  localparam int GAIN_LSB = 6;
  localparam int GAIN_MSB = 7;
  localparam logic [5:0] TIMER_RESET = 6'h00;
  localparam logic [1:0] GAIN_RESET = 2'h2;

  // ************************************************************
  // Status and control bits
  // ************************************************************
  localparam int DONE_BIT = 7;
  localparam int ERROR_BIT = 6;
  localparam int LOW_SUPPLY_BIT = 5;
  localparam int ACK_BIT = 4;
  localparam int IRQ_EN_BIT = 3;
  localparam int MON_EN_BIT = 2;
  localparam int CTS_BIT = 1;
  localparam int UNIT_RESET_BIT = 0;

  // ************************************************************
  // Divider, polarity and encoding fields
  // ************************************************************
  localparam int FRAC_W = 13;
  localparam int FRAC_HIGH_LSB = 5;
  localparam int FRAC_LOW_W = 5;
  localparam int FRAC_LOW_FIELD_LSB = 3;
  localparam int POL_BIT = 2;
  localparam int ENC_LSB = 0;
  localparam int ENC_MSB = 1;
  localparam logic [FRAC_W-1:0] FRAC_RESET = 13'h0000;
  localparam int RATIO_INT_W = 5;
  localparam logic [RATIO_INT_W-1:0] RATIO_INT_BASE = 5'h0C;
  localparam logic [RATIO_INT_W-1:0] RATIO_BAND_STEP = 5'h04;

  // ************************************************************
  // Frame numbering
  // ************************************************************
  localparam int FCOUNT_W = 4;
  localparam int FRAME_COUNT_FIELD_W = 5;
  localparam int GAP_W = 11;

  typedef enum logic [1:0] {
    ENC_MANCHESTER = 2'h0,
    ENC_BIPHASE = 2'h1,
    ENC_NRZ = 2'h2,
    ENC_DIRECT = 2'h3
  } rftcs_enc_type;

endpackage : rftcs_pkg

// ---- verilog/rftcs_regs.sv ----
// Control and status register bank of the on-chip RF transmitter unit.
// Functional notes
// - Interframe gap output is frame slot timer times last transmitted frame number.
// - Unit reset clears timer, sets upper gain bit, clears lower gain bit.
// - Done flag sets when buffered transmission ends after send request drops.
// - Software writes never change done, error or low supply flags directly.
// - Error flag sets on any transmission error and stays until cleared.
// - With monitor enabled, low supply sets sticky flag until cleared.
// - Acknowledge write of one clears all three flags; zero does nothing.
// - Unit reset clears the done, error and low supply flags.
// - Interrupt is raised when enabled and any flag is set.
// - Monitor enable switches detector on and routes events to flag.
// - Clear to send only when oscillator, VCO and PLL all locked.
// - Writing one to unit reset clears unit registers; bit reads zero.
// - Divider, polarity and encoding registers reachable only with page select clear.
// - Fraction bits 12:5 in first register, 4:0 in upper five of second.
// - Data zero ratio is 12 plus four times band plus fraction over 8192.
// - Polarity set inverts NRZ and direct data, selects alternate encodings.
// - Encoding selector: Manchester, Bi-Phase, NRZ, or direct processor drive.
// - NRZ mode lets software mix NRZ and Manchester at double bit rate.
// - Direct mode drives amplifier level from the direct data bit.
// - Frames per message equals frame count field plus one.
`timescale 1ns/1ps
`default_nettype none

module rftcs_regs (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Register port
  input wire logic [rftcs_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [rftcs_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [rftcs_pkg::DATA_W-1:0] reg_rdata,
  // Paging and neighbouring control
  input wire logic register_page_select,
  input wire logic carrier_band_select,
  input wire logic direct_data_bit,
  input wire logic [rftcs_pkg::FCOUNT_W-1:0] frame_count_field,
  input wire logic [rftcs_pkg::FRAME_COUNT_FIELD_W-1:0] last_frame_number,
  // Transmitter events and status
  input wire logic send_request,
  input wire logic buffer_tx_complete,
  input wire logic tx_error_event,
  input wire logic supply_below_threshold,
  input wire logic crystal_osc_locked,
  input wire logic vco_locked,
  input wire logic pll_locked,
  // Outputs to the transmitter
  output logic radio_unit_reset,
  output logic [1:0] osc_gain_select,
  output logic [rftcs_pkg::GAP_W-1:0] frame_gap_ms,
  output logic [rftcs_pkg::FRAME_COUNT_FIELD_W-1:0] frames_per_message,
  output logic supply_monitor_enable,
  output logic [rftcs_pkg::FRAC_W-1:0] zero_divider_fraction,
  output logic [rftcs_pkg::RATIO_INT_W+rftcs_pkg::FRAC_W-1:0] zero_synth_ratio,
  output logic polarity_select,
  output logic [1:0] encoding_select,
  output logic direct_mode,
  output logic pa_direct_level,
  output logic radio_irq
);
  import rftcs_pkg::*;

  // ************************************************************
  // Decode
  // ************************************************************
  // Paged registers vanish while the page select is set.
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] idx,
                                   input logic page);
    logic paged;
    paged = (idx == IDX_DIV_HIGH) || (idx == IDX_DIV_LOW_ENC);
    reg_hit = (addr == idx) && !(paged && page);
  endfunction : reg_hit

  logic [5:0] frame_slot_timer;
  logic tx_done_flag;
  logic tx_error_flag;
  logic low_supply_flag;
  logic radio_irq_enable;
  logic clear_to_send_status;
  logic [GAP_W-1:0] next_frame_gap;
  logic wr_timing;
  logic wr_status;
  logic wr_div_high;
  logic wr_div_low;
  logic flag_acknowledge;
  logic buffered_mode;
  logic done_event;
  logic low_event;
  logic done_visible;

  assign wr_timing = reg_write && reg_hit(reg_addr, IDX_FRAME_TIMING, register_page_select);
  assign wr_status = reg_write && reg_hit(reg_addr, IDX_STATUS_CTRL, register_page_select);
  assign wr_div_high = reg_write && reg_hit(reg_addr, IDX_DIV_HIGH, register_page_select);
  assign wr_div_low = reg_write && reg_hit(reg_addr, IDX_DIV_LOW_ENC, register_page_select);
  // The acknowledge bit is a pure action, so the unit reset has nothing of it to clear.
  assign flag_acknowledge = wr_status && reg_wdata[ACK_BIT];
  assign buffered_mode = (encoding_select != ENC_DIRECT);
  assign done_event = buffer_tx_complete && !send_request && buffered_mode;
  assign low_event = supply_monitor_enable && supply_below_threshold;
  assign done_visible = tx_done_flag && !send_request && buffered_mode;
  assign direct_mode = !buffered_mode;

  // ************************************************************
  // Unit reset
  // ************************************************************
  // A one-cycle pulse; the unit registers clear on the edge that ends it.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      radio_unit_reset <= 1'b0;
    end else begin
      radio_unit_reset <= wr_status && reg_wdata[UNIT_RESET_BIT];
    end
  end

  // ************************************************************
  // Frame slot timing
  // ************************************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      frame_slot_timer <= TIMER_RESET;
      osc_gain_select <= GAIN_RESET;
    end else if (radio_unit_reset) begin
      frame_slot_timer <= TIMER_RESET;
      osc_gain_select <= GAIN_RESET;
    end else if (wr_timing) begin
      frame_slot_timer <= reg_wdata[TIMER_MSB:TIMER_LSB];
      osc_gain_select <= reg_wdata[GAIN_MSB:GAIN_LSB];
    end
  end

  assign next_frame_gap = GAP_W'(frame_slot_timer * last_frame_number);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      frame_gap_ms <= '0;
      frames_per_message <= '0;
    end else begin
      frame_gap_ms <= next_frame_gap;
      frames_per_message <= FRAME_COUNT_FIELD_W'({1'b0, frame_count_field} + 5'h01);
    end
  end

  // ************************************************************
  // Sticky flags
  // ************************************************************
  // Set beats acknowledge so an event landing on the clear cycle survives.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tx_done_flag <= 1'b0;
      tx_error_flag <= 1'b0;
      low_supply_flag <= 1'b0;
    end else if (radio_unit_reset) begin
      tx_done_flag <= 1'b0;
      tx_error_flag <= 1'b0;
      low_supply_flag <= 1'b0;
    end else begin
      // Written data never lands here; only events and acknowledge move the flags.
      tx_done_flag <= done_event || (tx_done_flag && !flag_acknowledge);
      tx_error_flag <= tx_error_event || (tx_error_flag && !flag_acknowledge);
      low_supply_flag <= low_event || (low_supply_flag && !flag_acknowledge);
    end
  end

  // ************************************************************
  // Control bits and lock status
  // ************************************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      radio_irq_enable <= 1'b0;
      supply_monitor_enable <= 1'b0;
    end else if (radio_unit_reset) begin
      radio_irq_enable <= 1'b0;
      supply_monitor_enable <= 1'b0;
    end else if (wr_status) begin
      radio_irq_enable <= reg_wdata[IRQ_EN_BIT];
      supply_monitor_enable <= reg_wdata[MON_EN_BIT];
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      clear_to_send_status <= 1'b0;
    end else if (radio_unit_reset) begin
      clear_to_send_status <= 1'b0;
    end else begin
      clear_to_send_status <= crystal_osc_locked && vco_locked && pll_locked;
    end
  end

  assign radio_irq = radio_irq_enable && (tx_done_flag || tx_error_flag || low_supply_flag);

  // ************************************************************
  // Divider, polarity and encoding
  // ************************************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      zero_divider_fraction <= FRAC_RESET;
      polarity_select <= 1'b0;
      encoding_select <= ENC_MANCHESTER;
    end else if (radio_unit_reset) begin
      zero_divider_fraction <= FRAC_RESET;
      polarity_select <= 1'b0;
      encoding_select <= ENC_MANCHESTER;
    end else begin
      if (wr_div_high) begin
        zero_divider_fraction[FRAC_W-1:FRAC_HIGH_LSB] <= reg_wdata;
      end
      if (wr_div_low) begin
        zero_divider_fraction[FRAC_LOW_W-1:0] <= reg_wdata[DATA_W-1:FRAC_LOW_FIELD_LSB];
        polarity_select <= reg_wdata[POL_BIT];
        // NRZ passes buffer bits as they stand, so double-rate data can carry Manchester too.
        encoding_select <= reg_wdata[ENC_MSB:ENC_LSB];
      end
    end
  end

  // The ratio is held scaled by 8192: integer part above, fraction below.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      zero_synth_ratio <= '0;
      pa_direct_level <= 1'b0;
    end else begin
      zero_synth_ratio <= {RATIO_INT_BASE + (carrier_band_select ? RATIO_BAND_STEP : {RATIO_INT_W{1'b0}}),
                           zero_divider_fraction};
      pa_direct_level <= direct_mode && (direct_data_bit ^ polarity_select);
    end
  end

  // ************************************************************
  // Read data
  // ************************************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else if (!reg_read) begin
      reg_rdata <= '0;
    end else if (reg_hit(reg_addr, IDX_FRAME_TIMING, register_page_select)) begin
      reg_rdata <= {osc_gain_select, frame_slot_timer};
    end else if (reg_hit(reg_addr, IDX_STATUS_CTRL, register_page_select)) begin
      reg_rdata <= {done_visible, tx_error_flag, low_supply_flag, 1'b0, radio_irq_enable,
                    supply_monitor_enable, clear_to_send_status, 1'b0};
    end else if (reg_hit(reg_addr, IDX_DIV_HIGH, register_page_select)) begin
      reg_rdata <= zero_divider_fraction[FRAC_W-1:FRAC_HIGH_LSB];
    end else if (reg_hit(reg_addr, IDX_DIV_LOW_ENC, register_page_select)) begin
      reg_rdata <= {zero_divider_fraction[FRAC_LOW_W-1:0], polarity_select, encoding_select};
    end else begin
      reg_rdata <= '0;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  a_gap_product: assert property (@(posedge mclk) disable iff (!reset_n)
    1'b1 |=> frame_gap_ms == $past(next_frame_gap))
    else $error("Frame gap does not follow timer times frame number.");

  a_unit_reset_values: assert property (@(posedge mclk) disable iff (!reset_n)
    radio_unit_reset |=> frame_slot_timer == TIMER_RESET && osc_gain_select == GAIN_RESET
      && zero_divider_fraction == FRAC_RESET && encoding_select == ENC_MANCHESTER && !polarity_select
      && !tx_done_flag && !tx_error_flag && !low_supply_flag && !radio_irq_enable)
    else $error("Unit reset left a register uncleared.");

  a_write_ignores_flags: assert property (@(posedge mclk) disable iff (!reset_n)
    wr_status && !reg_wdata[ACK_BIT] && !tx_error_event && !radio_unit_reset |=> $stable(tx_error_flag))
    else $error("Plain write moved the error flag.");

  a_ack_clears_flags: assert property (@(posedge mclk) disable iff (!reset_n)
    flag_acknowledge && !done_event && !tx_error_event && !low_event
      |=> !tx_done_flag && !tx_error_flag && !low_supply_flag)
    else $error("Acknowledge did not clear the flags.");

  a_event_beats_ack: assert property (@(posedge mclk) disable iff (!reset_n)
    flag_acknowledge && tx_error_event && !radio_unit_reset |=> tx_error_flag)
    else $error("Error event lost to acknowledge.");

  a_low_supply_sets: assert property (@(posedge mclk) disable iff (!reset_n)
    supply_monitor_enable && supply_below_threshold && !radio_unit_reset
      |=> low_supply_flag ##1 (low_supply_flag || $past(flag_acknowledge) || $past(radio_unit_reset)))
    else $error("Low supply flag not set or not held.");

  a_irq_follows_flags: assert property (@(posedge mclk) disable iff (!reset_n)
    radio_irq |-> radio_irq_enable && (tx_done_flag || tx_error_flag || low_supply_flag))
    else $error("Interrupt raised without enable and flag.");

  a_cts_needs_lock: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(clear_to_send_status) |-> $past(crystal_osc_locked && vco_locked && pll_locked))
    else $error("Clear to send rose without all locks.");

  a_unit_reset_reads_zero: assert property (@(posedge mclk) disable iff (!reset_n)
    reg_read && reg_addr == IDX_STATUS_CTRL |=> reg_rdata[UNIT_RESET_BIT] == 1'b0)
    else $error("Unit reset bit read back as one.");

  a_page_blocks_write: assert property (@(posedge mclk) disable iff (!reset_n)
    reg_write && register_page_select && !radio_unit_reset |=> $stable(zero_divider_fraction))
    else $error("Divider changed while paged out.");

  a_ratio_formula: assert property (@(posedge mclk) disable iff (!reset_n)
    carrier_band_select && $stable(zero_divider_fraction) |=> zero_synth_ratio[FRAC_W+:RATIO_INT_W] == 5'h10)
    else $error("Ratio integer part wrong for upper band.");

  a_direct_level: assert property (@(posedge mclk) disable iff (!reset_n)
    direct_mode && $stable(encoding_select) |=> pa_direct_level == ($past(direct_data_bit) ^ $past(polarity_select)))
    else $error("Direct amplifier level does not follow data bit.");

  a_frame_total: assert property (@(posedge mclk) disable iff (!reset_n)
    frame_count_field == 4'hF |=> frames_per_message == 5'h10)
    else $error("Frames per message not count plus one.");

endmodule : rftcs_regs

`default_nettype wire

// ---- dv/rftcs_regs_test.sv ----
// Self-checking testbench for the transmitter control and status register bank.
`timescale 1ns/1ps
`default_nettype none

module rftcs_regs_test;
  import rftcs_pkg::*;

  // ************************************************************
  // Stimulus and observed signals
  // ************************************************************
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic register_page_select = 1'b0;
  logic carrier_band_select = 1'b0;
  logic direct_data_bit = 1'b0;
  logic [FCOUNT_W-1:0] frame_count_field = '0;
  logic [FRAME_COUNT_FIELD_W-1:0] last_frame_number = '0;
  logic send_request = 1'b0;
  logic buffer_tx_complete = 1'b0;
  logic tx_error_event = 1'b0;
  logic supply_below_threshold = 1'b0;
  logic crystal_osc_locked = 1'b0;
  logic vco_locked = 1'b0;
  logic pll_locked = 1'b0;
  logic radio_unit_reset;
  logic [1:0] osc_gain_select;
  logic [GAP_W-1:0] frame_gap_ms;
  logic [FRAME_COUNT_FIELD_W-1:0] frames_per_message;
  logic supply_monitor_enable;
  logic [FRAC_W-1:0] zero_divider_fraction;
  logic [RATIO_INT_W+FRAC_W-1:0] zero_synth_ratio;
  logic polarity_select;
  logic [1:0] encoding_select;
  logic direct_mode;
  logic pa_direct_level;
  logic radio_irq;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;

  rftcs_regs rftcs_regs_i (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .register_page_select(register_page_select), .carrier_band_select(carrier_band_select),
    .direct_data_bit(direct_data_bit), .frame_count_field(frame_count_field),
    .last_frame_number(last_frame_number), .send_request(send_request),
    .buffer_tx_complete(buffer_tx_complete), .tx_error_event(tx_error_event),
    .supply_below_threshold(supply_below_threshold), .crystal_osc_locked(crystal_osc_locked),
    .vco_locked(vco_locked), .pll_locked(pll_locked), .radio_unit_reset(radio_unit_reset),
    .osc_gain_select(osc_gain_select), .frame_gap_ms(frame_gap_ms), .frames_per_message(frames_per_message),
    .supply_monitor_enable(supply_monitor_enable), .zero_divider_fraction(zero_divider_fraction),
    .zero_synth_ratio(zero_synth_ratio), .polarity_select(polarity_select), .encoding_select(encoding_select),
    .direct_mode(direct_mode), .pa_direct_level(pa_direct_level), .radio_irq(radio_irq));

  always #2 mclk = ~mclk;

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic stop_test;
    if (errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: register read %h, expected %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_out(input logic [17:0] got, input logic [17:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: output %h, expected %h", $time, got, exp);
    end
  endtask : chk_out

  // An idle cycle after each strobe keeps a strobe from being assigned twice in one time step.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
    #1;
    chk_reg(reg_rdata, exp);
    @(posedge mclk);
  endtask : rd

  task automatic settle;
    repeat (2) @(posedge mclk);
  endtask : settle

  // ************************************************************
  // Cycle limit
  // ************************************************************
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      $display("Error at %0t: cycle limit reached", $time);
      stop_test();
    end
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    chk_out(osc_gain_select, 18'h2);
    rd(IDX_FRAME_TIMING, 8'h80);
    #1;
    chk_reg(reg_rdata, 8'h00);
    @(posedge mclk);
    rd(IDX_STATUS_CTRL, 8'h00);
    rd(IDX_DIV_HIGH, 8'h00);
    rd(IDX_DIV_LOW_ENC, 8'h00);
    // Largest timer value times two frame numbers, the second at the top of its range.
    last_frame_number <= 5'd5;
    frame_count_field <= 4'hF;
    wr(IDX_FRAME_TIMING, 8'h7F);
    rd(IDX_FRAME_TIMING, 8'h7F);
    chk_out(osc_gain_select, 18'h1);
    chk_out(frame_gap_ms, 18'd315);
    chk_out(frames_per_message, 18'd16);
    last_frame_number <= 5'd31;
    frame_count_field <= 4'h0;
    settle();
    chk_out(frame_gap_ms, 18'd1953);
    chk_out(frames_per_message, 18'd1);
    // Divider halves, polarity and encoding.
    carrier_band_select <= 1'b1;
    wr(IDX_DIV_HIGH, 8'hAB);
    wr(IDX_DIV_LOW_ENC, 8'hAE);
    chk_out(zero_divider_fraction, 18'h1575);
    // The ratio register follows the divider one edge later.
    @(posedge mclk);
    chk_out(zero_synth_ratio, (18'd16 << 13) | 18'h1575);
    chk_out(polarity_select, 18'h1);
    carrier_band_select <= 1'b0;
    settle();
    chk_out(zero_synth_ratio, (18'd12 << 13) | 18'h1575);
    register_page_select <= 1'b1;
    wr(IDX_DIV_HIGH, 8'h12);
    rd(IDX_DIV_HIGH, 8'h00);
    chk_out(zero_divider_fraction, 18'h1575);
    register_page_select <= 1'b0;
    rd(IDX_DIV_HIGH, 8'hAB);
    rd(IDX_DIV_LOW_ENC, 8'hAE);
    for (int e = 0; e < 4; e++) begin
      wr(IDX_DIV_LOW_ENC, {5'h15, 1'b0, 2'(e)});
      chk_out(encoding_select, 18'(e));
      chk_out(direct_mode, {17'h0, e == 3});
    end
    direct_data_bit <= 1'b1;
    settle();
    chk_out(pa_direct_level, 18'h1);
    wr(IDX_DIV_LOW_ENC, 8'hAF);
    settle();
    chk_out(pa_direct_level, 18'h0);
    direct_data_bit <= 1'b0;
    settle();
    chk_out(pa_direct_level, 18'h1);
    wr(IDX_DIV_LOW_ENC, 8'hAE);
    settle();
    chk_out(pa_direct_level, 18'h0);
    // Error flag, interrupt, ignored flag writes and acknowledge.
    wr(IDX_STATUS_CTRL, 8'h08);
    chk_out(radio_irq, 18'h0);
    tx_error_event <= 1'b1;
    @(posedge mclk);
    tx_error_event <= 1'b0;
    @(posedge mclk);
    chk_out(radio_irq, 18'h1);
    rd(IDX_STATUS_CTRL, 8'h48);
    wr(IDX_STATUS_CTRL, 8'hE8);
    rd(IDX_STATUS_CTRL, 8'h48);
    wr(IDX_STATUS_CTRL, 8'h18);
    rd(IDX_STATUS_CTRL, 8'h08);
    chk_out(radio_irq, 18'h0);
    wr(IDX_STATUS_CTRL, 8'h00);
    tx_error_event <= 1'b1;
    @(posedge mclk);
    tx_error_event <= 1'b0;
    @(posedge mclk);
    chk_out(radio_irq, 18'h0);
    // An event in the acknowledge cycle must survive it.
    wr(IDX_STATUS_CTRL, 8'h10);
    tx_error_event <= 1'b1;
    reg_addr <= IDX_STATUS_CTRL;
    reg_wdata <= 8'h10;
    reg_write <= 1'b1;
    @(posedge mclk);
    tx_error_event <= 1'b0;
    reg_write <= 1'b0;
    @(posedge mclk);
    rd(IDX_STATUS_CTRL, 8'h40);
    wr(IDX_STATUS_CTRL, 8'h10);
    // Low supply flag only with the monitor on, and sticky.
    supply_below_threshold <= 1'b1;
    settle();
    rd(IDX_STATUS_CTRL, 8'h00);
    wr(IDX_STATUS_CTRL, 8'h04);
    chk_out(supply_monitor_enable, 18'h1);
    supply_below_threshold <= 1'b0;
    rd(IDX_STATUS_CTRL, 8'h24);
    wr(IDX_STATUS_CTRL, 8'h04);
    rd(IDX_STATUS_CTRL, 8'h24);
    wr(IDX_STATUS_CTRL, 8'h14);
    rd(IDX_STATUS_CTRL, 8'h04);
    // Done flag only once the send request has dropped.
    send_request <= 1'b1;
    buffer_tx_complete <= 1'b1;
    @(posedge mclk);
    buffer_tx_complete <= 1'b0;
    send_request <= 1'b0;
    @(posedge mclk);
    rd(IDX_STATUS_CTRL, 8'h04);
    buffer_tx_complete <= 1'b1;
    @(posedge mclk);
    buffer_tx_complete <= 1'b0;
    @(posedge mclk);
    rd(IDX_STATUS_CTRL, 8'h84);
    // The kept done flag reads as zero while a new send is requested.
    send_request <= 1'b1;
    rd(IDX_STATUS_CTRL, 8'h04);
    send_request <= 1'b0;
    // Clear to send needs all three locks.
    crystal_osc_locked <= 1'b1;
    vco_locked <= 1'b1;
    settle();
    rd(IDX_STATUS_CTRL, 8'h84);
    pll_locked <= 1'b1;
    settle();
    rd(IDX_STATUS_CTRL, 8'h86);
    wr(IDX_STATUS_CTRL, 8'h0C);
    chk_out(radio_irq, 18'h1);
    crystal_osc_locked <= 1'b0;
    // Unit reset pulse and the state it leaves behind.
    wr(IDX_STATUS_CTRL, 8'h01);
    chk_out(radio_unit_reset, 18'h1);
    @(posedge mclk);
    chk_out(radio_unit_reset, 18'h0);
    chk_out(osc_gain_select, 18'h2);
    chk_out(radio_irq, 18'h0);
    @(posedge mclk);
    chk_out(zero_synth_ratio, 18'd12 << 13);
    chk_out(polarity_select, 18'h0);
    chk_out(supply_monitor_enable, 18'h0);
    rd(IDX_FRAME_TIMING, 8'h80);
    rd(IDX_STATUS_CTRL, 8'h00);
    rd(IDX_DIV_HIGH, 8'h00);
    rd(IDX_DIV_LOW_ENC, 8'h00);
    stop_test();
  end

endmodule : rftcs_regs_test

`default_nettype wire
